// [common/vcr_defs.vh]
// Constants for the VC0 resource register group: offsets, fields, resets
// Assumes 12-bit configuration byte addresses and 32-bit register words
`ifndef VCR_DEFS_VH
`define VCR_DEFS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define VCR_OFS_CAP        12'h150
`define VCR_OFS_CTRL       12'h154
`define VCR_OFS_STAT       12'h158

// ************************************************************
// Capability word fields and values
// ************************************************************
`define VCR_CAP_PARB       8'h09
`define VCR_CAP_ASO        1'b0
`define VCR_CAP_REJSNP     1'b0
`define VCR_CAP_MAXSLOT    7'h7f
`define VCR_CAP_TBLOFS     8'h04

// ************************************************************
// Control word fields and resets
// ************************************************************
`define VCR_CTL_LOAD_BIT   16
`define VCR_CTL_SEL_LSB    17
`define VCR_CTL_VCID_LSB   24
`define VCR_CTL_EN_BIT     31
`define VCR_RST_TCMAP      8'hff
`define VCR_RST_SEL        3'h0
`define VCR_SEL_ALT        3'h3
`define VCR_VCID           3'h0
`define VCR_RST_EN         1'b1

// ************************************************************
// Status word fields
// ************************************************************
`define VCR_STAT_DIRTY_BIT 16
`define VCR_STAT_NEG_BIT   17

// ************************************************************
// Arbitration table shape
// ************************************************************
`define VCR_WRR_PHASES     128
`define VCR_PHASE_W        7
`define VCR_ENTRY_W        4
`define VCR_LAST_PHASE     7'h7f
`define VCR_PORTS_LO       3'h3
`define VCR_PORTS_HI       3'h4

`endif

// [dv/vcr_regs_bench.sv]
// Self-checking bench for the VC0 resource register group
// Assumes vcr_regs alone, driven straight at its ports
`timescale 1ns/1ps
`include "vcr_defs.vh"

module vcr_regs_bench;
  // ************************************************************
  // Signals
  // ************************************************************
  reg         clk, nrst, cfg_req, cfg_wr, sb_tcmap_wr, ee_tcmap_vld, tbl_sw_wr, arb_advance, vc_neg_busy;
  reg  [11:0] cfg_addr;
  reg  [3:0]  cfg_be, b;
  reg  [31:0] cfg_wdata, rd, sh, d;
  reg  [7:0]  sb_tcmap_data, ee_tcmap_data;
  reg  [2:0]  ports_enabled;
  reg  [6:0]  p;
  wire        cfg_ack_ff, wrr_active_ff, vc_active_ff, tbl_loading;
  wire [31:0] cfg_rdata_ff;
  wire [6:0]  prog_idx, arb_phase_ff;
  wire [3:0]  prog_entry, arb_entry;
  wire [7:0]  tc_map_ff;
  wire [2:0]  arb_sel_ff;
  integer     num_errors, n_tests, i, k;
  event       all_done;

  vcr_regs dut (.clk, .nrst, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack_ff, .cfg_rdata_ff,
    .sb_tcmap_wr, .sb_tcmap_data, .ee_tcmap_vld, .ee_tcmap_data, .tbl_sw_wr, .prog_idx, .prog_entry,
    .ports_enabled, .arb_advance, .vc_neg_busy, .tc_map_ff, .arb_sel_ff, .wrr_active_ff, .arb_phase_ff,
    .arb_entry, .vc_active_ff, .tbl_loading);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Programmed table answers in the same cycle, all four bits used
  function [3:0] ent(input [6:0] x);
    ent = x[3:0] ^ {1'b0, x[6:4]};
  endfunction
  function [31:0] ctl(input [31:0] s);
    ctl = {s[31], 11'h0, s[19:17], 9'h0, s[7:0]};
  endfunction
  function [2:0] eff(input [2:0] s);
    eff = (s == 3'h3) ? 3'h3 : 3'h0;
  endfunction
  assign prog_entry = ent(prog_idx);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task summarize;
    begin
      if (num_errors == 0 && n_tests > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // The only place the run ends; timeouts and the normal path both land here
  initial begin
    @(all_done);
    summarize;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // Request lasts one edge; ack is awaited under a bound
  task cfg(input w, input [11:0] a, input [3:0] be, input [31:0] dd);
    integer n;
    begin
      @(posedge clk);
      cfg_req <= 1'b1;
      cfg_wr <= w;
      cfg_addr <= a;
      cfg_be <= be;
      cfg_wdata <= dd;
      @(posedge clk);
      cfg_req <= 1'b0;
      #1;
      n = 0;
      while (cfg_ack_ff !== 1'b1 && n < 4) begin
        cyc(1);
        n = n + 1;
      end
      if (n == 4) begin
        num_errors = num_errors + 1;
        -> all_done;
      end
      rd = cfg_rdata_ff;
    end
  endtask
  task rchk(input [11:0] a, input [31:0] exp);
    begin
      cfg(1'b0, a, 4'h0, 32'h0);
      chk(rd, exp);
    end
  endtask
  // One-cycle pulse: 0 sideband, 1 eeprom, 2 table write, 3 advance
  task pl(input [1:0] wh, input [7:0] v);
    begin
      @(posedge clk);
      sb_tcmap_wr <= (wh == 2'd0);
      ee_tcmap_vld <= (wh == 2'd1);
      tbl_sw_wr <= (wh == 2'd2);
      arb_advance <= (wh == 2'd3);
      sb_tcmap_data <= v;
      ee_tcmap_data <= v;
      @(posedge clk);
      sb_tcmap_wr <= 1'b0;
      ee_tcmap_vld <= 1'b0;
      tbl_sw_wr <= 1'b0;
      arb_advance <= 1'b0;
      cyc(2);
    end
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    {nrst, cfg_req, cfg_wr, sb_tcmap_wr, ee_tcmap_vld, tbl_sw_wr, arb_advance, vc_neg_busy} = 8'h0;
    {cfg_addr, cfg_be, cfg_wdata, sb_tcmap_data, ee_tcmap_data, ports_enabled} = 67'h0;
    num_errors = 0;
    n_tests = 0;
    void'($urandom(12));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    pl(2'd0, 8'h5a);
    chk(tc_map_ff, 8'h5a);
    pl(2'd1, 8'h3c);
    chk(tc_map_ff, 8'h3c);
    sh = 32'h8000_003c;
    rchk(12'h150, 32'h047f0009);
    rchk(12'h154, ctl(sh));
    rchk(12'h158, 32'h0);
    chk(vc_active_ff, 1'b1);
    cfg(1'b1, 12'h150, 4'hf, 32'hffff_ffff);
    cfg(1'b1, 12'h158, 4'hf, 32'hffff_ffff);
    cfg(1'b1, 12'h15c, 4'hf, 32'hffff_ffff);
    rchk(12'h150, 32'h047f0009);
    rchk(12'h158, 32'h0);
    rchk(12'h15c, 32'h0);
    // Every select code first, then random lanes and data
    for (i = 0; i < 20; i = i + 1) begin
      d = $urandom & 32'hfffe_ffff;
      b = (i < 8) ? 4'hf : d[11:8];
      if (i < 8)
        d[19:17] = i[2:0];
      cfg(1'b1, 12'h154, b, d);
      if (b[0])
        sh[7:0] = d[7:0];
      if (b[2])
        sh[19:17] = d[19:17];
      if (b[3])
        sh[31] = d[31];
      rchk(12'h154, ctl(sh));
      chk(arb_sel_ff, eff(sh[19:17]));
      chk(tc_map_ff, sh[7:0]);
    end
    pl(2'd0, ~sh[7:0]);
    chk(tc_map_ff, sh[7:0]);
    pl(2'd2, 8'h0);
    rchk(12'h158, 32'h0001_0000);
    sh[19:17] = 3'h3;
    cfg(1'b1, 12'h154, 4'h4, 32'h0007_0000);
    // Still dirty while the copy runs
    rchk(12'h158, 32'h0001_0000);
    k = 0;
    while (tbl_loading === 1'b1 && k < 300) begin
      cyc(1);
      k = k + 1;
    end
    if (k == 300) begin
      num_errors = num_errors + 1;
      -> all_done;
    end
    cyc(3);
    rchk(12'h158, 32'h0);
    rchk(12'h154, ctl(sh));
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk);
      ports_enabled <= i[2:0];
      cyc(3);
      chk(wrr_active_ff, (i == 3 || i == 4));
    end
    @(posedge clk);
    ports_enabled <= 3'h4;
    cyc(3);
    // Walk past phase 127 to see the wrap
    p = 7'h0;
    for (i = 0; i < 130; i = i + 1) begin
      chk(arb_phase_ff, p);
      chk(arb_entry, ent(p));
      pl(2'd3, 8'h0);
      p = p + 7'h1;
    end
    @(posedge clk);
    vc_neg_busy <= 1'b1;
    cyc(2);
    rchk(12'h158, 32'h0002_0000);
    @(posedge clk);
    vc_neg_busy <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rchk(12'h158, 32'h0);
    rchk(12'h154, 32'h8000_00ff);
    -> all_done;
  end
endmodule

// [dv/vcr_regs_properties.sv]
// Concurrent checks on the VC0 resource register group ports
// Assumes a bind onto vcr_regs, one clock, active-low async reset
`timescale 1ns/1ps

module vcr_regs_props (
  // Clock and reset
  input wire        clk,
  input wire        nrst,
  // Configuration access
  input wire        cfg_req,
  input wire        cfg_wr,
  input wire [11:0] cfg_addr,
  input wire [3:0]  cfg_be,
  input wire [31:0] cfg_wdata,
  input wire        cfg_ack_ff,
  input wire [31:0] cfg_rdata_ff,
  // Arbiter side
  input wire [2:0]  ports_enabled,
  input wire        vc_neg_busy,
  input wire [7:0]  tc_map_ff,
  input wire [2:0]  arb_sel_ff,
  input wire        wrr_active_ff,
  input wire        vc_active_ff,
  input wire        tbl_loading
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rd     = cfg_req & ~cfg_wr;
  wire wr_ctl = cfg_req & cfg_wr & (cfg_addr == 12'h154);

  a_ack_timing: assert property (cfg_req |=> cfg_ack_ff)
    else $error("ack missing after request");
  a_ack_cause: assert property (cfg_ack_ff |-> $past(cfg_req))
    else $error("ack without request");
  a_cap_value: assert property (rd && cfg_addr == 12'h150 |=> cfg_rdata_ff == 32'h047f0009)
    else $error("capability word wrong");
  a_ctrl_fixed: assert property (rd && cfg_addr == 12'h154 |=> cfg_rdata_ff[30:20] == 11'h0 && cfg_rdata_ff[16:8] == 9'h0)
    else $error("control fixed bits wrong");
  a_stat_rsvd: assert property (rd && cfg_addr == 12'h158 |=> cfg_rdata_ff[15:0] == 16'h0 && cfg_rdata_ff[31:18] == 14'h0)
    else $error("status reserved bits set");
  a_unmapped_zero: assert property (rd && !(cfg_addr inside {12'h150, 12'h154, 12'h158}) |=> cfg_rdata_ff == 32'h0)
    else $error("unmapped read not zero");
  a_neg_status: assert property (rd && cfg_addr == 12'h158 |=> cfg_rdata_ff[17] == $past(vc_neg_busy, 2))
    else $error("negotiation flag wrong");
  a_tc_write: assert property (wr_ctl && cfg_be[0] |=> tc_map_ff == $past(cfg_wdata[7:0]))
    else $error("tc map not written");
  a_sel_legal: assert property (arb_sel_ff == 3'h0 || arb_sel_ff == 3'h3)
    else $error("illegal effective select");
  a_wrr_ports: assert property (!(ports_enabled inside {3'h3, 3'h4}) [*2] |-> !wrr_active_ff)
    else $error("wrr active with wrong port count");
  a_load_span: assert property ($rose(tbl_loading) |-> ##128 tbl_loading ##1 !tbl_loading)
    else $error("table load length wrong");
  a_vc_stays: assert property ($past(nrst) |-> vc_active_ff)
    else $error("vc0 not active");

  c_load: cover property ($rose(tbl_loading));
  c_wrr: cover property (wrr_active_ff);
  c_unmapped: cover property (rd && cfg_addr == 12'h15c);
endmodule

bind vcr_regs vcr_regs_props u_props (.clk, .nrst, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
  .cfg_ack_ff, .cfg_rdata_ff, .ports_enabled, .vc_neg_busy, .tc_map_ff, .arb_sel_ff, .wrr_active_ff,
  .vc_active_ff, .tbl_loading);

// [hdl/vcr_preload.v]
// Pre-use override of the traffic class map from sideband or EEPROM load
// Assumes the sideband and loader strobes are one-cycle pulses on clk
`timescale 1ns/1ps
`include "vcr_defs.vh"

module vcr_preload (
  // Clock and reset
  input  wire       clk,
  input  wire       nrst,
  // Override sources
  input  wire       sb_tcmap_wr,
  input  wire [7:0] sb_tcmap_data,
  input  wire       ee_tcmap_vld,
  input  wire [7:0] ee_tcmap_data,
  // Lock once software has touched the control word
  input  wire       sw_used,
  // Result toward the register bank
  output reg        pl_vld_ff,
  output reg  [7:0] pl_data_ff
);

  // ************************************************************
  // Override capture
  // ************************************************************
  reg       locked_ff;
  reg       nxt_vld;
  reg [7:0] nxt_data;

  // Sideband wins a same-cycle tie; it is the later, deliberate source
  always @* begin
    nxt_vld  = 1'b0;
    nxt_data = pl_data_ff;
    if (!locked_ff && !sw_used) begin
      if (sb_tcmap_wr) begin
        nxt_vld  = 1'b1;
        nxt_data = sb_tcmap_data;
      end else if (ee_tcmap_vld) begin
        nxt_vld  = 1'b1;
        nxt_data = ee_tcmap_data;
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      locked_ff  <= 1'b0;
      pl_vld_ff  <= 1'b0;
      pl_data_ff <= `VCR_RST_TCMAP;
    end else begin
      pl_vld_ff  <= nxt_vld;
      pl_data_ff <= nxt_data;
      if (sw_used) begin
        locked_ff <= 1'b1;
      end
    end
  end

endmodule

// [hdl/vcr_regs.v]
// VC0 resource register group: capability, control and status words
// Assumes one-cycle configuration requests; the answer follows one cycle later
//
// How it works
// - Port arbitration capability byte is read-only and reads 09h.
// - Weighted round robin uses 128 phases with three to four ports enabled.
// - Capability bit 14, advanced-switching-only flag, is read-only zero.
// - Capability bit 15, snoop rejection flag, is read-only zero.
// - Capability bits 22:16 report time slots minus one, reading 7Fh.
// - Capability bits 31:24 give table offset in 16-byte units, 04h.
// - Control bits 7:0 map traffic class n here when bit n set; reset FFh.
// - Traffic class map default may be overridden by sideband or EEPROM first.
// - Writing one to control bit 16 applies the table; reads zero.
// - Arbitration select 19:17 accepts 000b and 011b; others act as default.
// - Control bits 26:24, the VC identifier, read-only 000b.
// - Control bit 31 enable resets to one; VC0 stays active regardless.
// - Status bit 16 sets when software writes any table entry.
// - Status bit 16 clears once hardware finishes loading after a load.
// - Status bit 17 follows negotiation in progress; resets to zero.
// - Each held arbitration table entry is four bits wide.
`timescale 1ns/1ps
`include "vcr_defs.vh"

module vcr_regs (
  // Clock and reset
  input  wire                    clk,
  input  wire                    nrst,
  // Configuration access
  input  wire                    cfg_req,
  input  wire                    cfg_wr,
  input  wire [11:0]             cfg_addr,
  input  wire [3:0]              cfg_be,
  input  wire [31:0]             cfg_wdata,
  output reg                     cfg_ack_ff,
  output reg  [31:0]             cfg_rdata_ff,
  // Traffic class map override before software use
  input  wire                    sb_tcmap_wr,
  input  wire [7:0]              sb_tcmap_data,
  input  wire                    ee_tcmap_vld,
  input  wire [7:0]              ee_tcmap_data,
  // Programmed table side
  input  wire                    tbl_sw_wr,
  output wire [`VCR_PHASE_W-1:0] prog_idx,
  input  wire [`VCR_ENTRY_W-1:0] prog_entry,
  // Arbiter side
  input  wire [2:0]              ports_enabled,
  input  wire                    arb_advance,
  input  wire                    vc_neg_busy,
  output reg  [7:0]              tc_map_ff,
  output reg  [2:0]              arb_sel_ff,
  output reg                     wrr_active_ff,
  output reg  [`VCR_PHASE_W-1:0] arb_phase_ff,
  output wire [`VCR_ENTRY_W-1:0] arb_entry,
  output reg                     vc_active_ff,
  output wire                    tbl_loading
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Merges one byte lane under its enable
  function [7:0] lane_merge;
    input [7:0] old_val;
    input [7:0] new_val;
    input       en;
    begin
      lane_merge = en ? new_val : old_val;
    end
  endfunction

  // Illegal selections fall back to the default scheme
  function [2:0] sel_legal;
    input [2:0] raw;
    begin
      if (raw == `VCR_SEL_ALT) begin
        sel_legal = `VCR_SEL_ALT;
      end else begin
        sel_legal = `VCR_RST_SEL;
      end
    end
  endfunction

  // ************************************************************
  // Address decode
  // ************************************************************
  reg hit_cap;
  reg hit_ctrl;
  reg hit_stat;

  always @* begin
    hit_cap  = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (cfg_addr == `VCR_OFS_CAP) begin
      hit_cap = 1'b1;
    end else if (cfg_addr == `VCR_OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (cfg_addr == `VCR_OFS_STAT) begin
      hit_stat = 1'b1;
    end
  end

  wire ctrl_wr = cfg_req && cfg_wr && hit_ctrl;

  // ************************************************************
  // Traffic class map override
  // ************************************************************
  wire       pl_vld;
  wire [7:0] pl_data;
  reg        sw_used_ff;

  // Locks on the first control write so software always has the last word
  vcr_preload u_preload (
    .clk           (clk),
    .nrst          (nrst),
    .sb_tcmap_wr   (sb_tcmap_wr),
    .sb_tcmap_data (sb_tcmap_data),
    .ee_tcmap_vld  (ee_tcmap_vld),
    .ee_tcmap_data (ee_tcmap_data),
    .sw_used       (sw_used_ff | ctrl_wr),
    .pl_vld_ff     (pl_vld),
    .pl_data_ff    (pl_data)
  );

  // ************************************************************
  // Control word
  // ************************************************************
  reg [2:0] sel_raw_ff;
  reg       en_ff;
  reg [7:0] nxt_tc_map;
  reg [2:0] nxt_sel_raw;
  reg       nxt_en;
  reg       load_req;
  reg [7:0] lane2;
  reg [7:0] lane3;

  always @* begin
    nxt_tc_map  = tc_map_ff;
    nxt_sel_raw = sel_raw_ff;
    nxt_en      = en_ff;
    load_req    = 1'b0;
    lane2       = lane_merge(8'h00, cfg_wdata[23:16], cfg_be[2]);
    lane3       = lane_merge(8'h00, cfg_wdata[31:24], cfg_be[3]);
    if (pl_vld) begin
      nxt_tc_map = pl_data;
    end
    if (ctrl_wr) begin
      // A preload landing in the same cycle survives a write that skips lane 0
      nxt_tc_map = lane_merge(nxt_tc_map, cfg_wdata[7:0], cfg_be[0]);
      if (cfg_be[2]) begin
        nxt_sel_raw = lane2[3:1];
        load_req    = lane2[0];
      end
      if (cfg_be[3]) begin
        nxt_en = lane3[7];
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tc_map_ff  <= `VCR_RST_TCMAP;
      sel_raw_ff <= `VCR_RST_SEL;
      en_ff      <= `VCR_RST_EN;
      sw_used_ff <= 1'b0;
    end else begin
      tc_map_ff  <= nxt_tc_map;
      sel_raw_ff <= nxt_sel_raw;
      en_ff      <= nxt_en;
      if (ctrl_wr) begin
        sw_used_ff <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Table load and dirty flag
  // ************************************************************
  wire load_done;
  wire load_busy;
  reg  dirty_ff;
  reg  neg_ff;

  // A load asked for while one runs is dropped; the copy already covers it
  vcr_tbl_load u_tbl_load (
    .clk           (clk),
    .nrst          (nrst),
    .start         (load_req & ~load_busy),
    .busy          (load_busy),
    .done_ff       (load_done),
    .prog_idx_ff   (prog_idx),
    .prog_entry    (prog_entry),
    .arb_phase_idx (arb_phase_ff),
    .arb_entry_ff  (arb_entry)
  );

  assign tbl_loading = load_busy;

  // Set wins over the clear so a late table write is never lost
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dirty_ff <= 1'b0;
      neg_ff   <= 1'b0;
    end else begin
      if (tbl_sw_wr) begin
        dirty_ff <= 1'b1;
      end else if (load_done) begin
        dirty_ff <= 1'b0;
      end
      neg_ff <= vc_neg_busy;
    end
  end

  // ************************************************************
  // Arbiter steering
  // ************************************************************
  wire wrr_ports = (ports_enabled >= `VCR_PORTS_LO) && (ports_enabled <= `VCR_PORTS_HI);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arb_sel_ff    <= `VCR_RST_SEL;
      wrr_active_ff <= 1'b0;
      arb_phase_ff  <= {`VCR_PHASE_W{1'b0}};
      vc_active_ff  <= 1'b0;
    end else begin
      arb_sel_ff    <= sel_legal(sel_raw_ff);
      wrr_active_ff <= (sel_legal(sel_raw_ff) == `VCR_SEL_ALT) && wrr_ports;
      // Enable is stored but cannot switch VC0 off
      vc_active_ff  <= 1'b1;
      if (!wrr_active_ff) begin
        arb_phase_ff <= {`VCR_PHASE_W{1'b0}};
      end else if (arb_advance) begin
        // Seven-bit phase wraps after phase 127
        arb_phase_ff <= arb_phase_ff + 1'b1;
      end
    end
  end

  // ************************************************************
  // Read data and answer
  // ************************************************************
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h0000_0000;
    if (hit_cap) begin
      rd_word[7:0]   = `VCR_CAP_PARB;
      rd_word[14]    = `VCR_CAP_ASO;
      rd_word[15]    = `VCR_CAP_REJSNP;
      rd_word[22:16] = `VCR_CAP_MAXSLOT;
      rd_word[31:24] = `VCR_CAP_TBLOFS;
    end else if (hit_ctrl) begin
      rd_word[7:0]                     = tc_map_ff;
      rd_word[`VCR_CTL_LOAD_BIT]       = 1'b0;
      rd_word[`VCR_CTL_SEL_LSB+:3]     = sel_raw_ff;
      rd_word[`VCR_CTL_VCID_LSB+:3]    = `VCR_VCID;
      rd_word[`VCR_CTL_EN_BIT]         = en_ff;
    end else if (hit_stat) begin
      rd_word[`VCR_STAT_DIRTY_BIT] = dirty_ff;
      rd_word[`VCR_STAT_NEG_BIT]   = neg_ff;
    end
  end

  // Unmapped addresses still answer, with zero data
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ack_ff   <= 1'b0;
      cfg_rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_ack_ff <= cfg_req;
      if (cfg_req && !cfg_wr) begin
        cfg_rdata_ff <= rd_word;
      end
    end
  end

endmodule

// [hdl/vcr_tbl_load.v]
// Copies the programmed port arbitration table into the applied table
// Assumes the programmed table answers its index within the same cycle
`timescale 1ns/1ps
`include "vcr_defs.vh"

module vcr_tbl_load (
  // Clock and reset
  input  wire                    clk,
  input  wire                    nrst,
  // Control
  input  wire                    start,
  output wire                    busy,
  output reg                     done_ff,
  // Programmed table read
  output reg  [`VCR_PHASE_W-1:0] prog_idx_ff,
  input  wire [`VCR_ENTRY_W-1:0] prog_entry,
  // Applied table read by the arbiter
  input  wire [`VCR_PHASE_W-1:0] arb_phase_idx,
  output reg  [`VCR_ENTRY_W-1:0] arb_entry_ff
);

  // ************************************************************
  // Copy sequencer
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_COPY = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0]              state_ff;
  reg [`VCR_ENTRY_W-1:0] tbl_ff [0:`VCR_WRR_PHASES-1];
  integer                i;

  assign busy = (state_ff != ST_IDLE);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff    <= ST_IDLE;
      done_ff     <= 1'b0;
      prog_idx_ff <= {`VCR_PHASE_W{1'b0}};
      for (i = 0; i < `VCR_WRR_PHASES; i = i + 1) begin
        tbl_ff[i] <= {`VCR_ENTRY_W{1'b0}};
      end
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          prog_idx_ff <= {`VCR_PHASE_W{1'b0}};
          if (start) begin
            state_ff <= ST_COPY;
          end
        end
        ST_COPY: begin
          tbl_ff[prog_idx_ff] <= prog_entry;
          prog_idx_ff         <= prog_idx_ff + 1'b1;
          if (prog_idx_ff == `VCR_LAST_PHASE) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          done_ff  <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Applied table read
  // ************************************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arb_entry_ff <= {`VCR_ENTRY_W{1'b0}};
    end else begin
      arb_entry_ff <= tbl_ff[arb_phase_idx];
    end
  end

endmodule
